// File: hdl/sbl_pkg.sv
// Purpose: Shared constants for the secondary block lock register.
// Assumes: 32-bit APB data, byte addressing, little-endian bit order.
// Notes:   Bit 31 of the bus word is the enable, bit 20 the test/shadow
//          lock, bits 3:0 the low-space sector locks (bits 15:4 read as ones).
package sbl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] SECONDARY_BLOCK_LOCK_OFS = 12'h00C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SLE_BIT = 31;
  localparam int STS_BIT = 20;
  localparam int LOW_W = 16;
  localparam int SEC_N = 4;

  // ----------------------------------------------------------------
  // Password and reset values
  // ----------------------------------------------------------------
  // Value as printed is 36 bits; the bus carries its upper 32 bits
  localparam logic [35:0] PWD_PRINTED = 36'hC3C333333;
  localparam logic [31:0] PWD = PWD_PRINTED[35:4];
  // Erased nonvolatile word: every lock set
  localparam logic RST_LOCK = 1'b1;
  localparam logic [3:0] SEC_PRESENT_DEF = 4'hF;
  localparam logic [11:0] LOW_UNUSED_ONES = 12'hFFF;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SBL_LOAD,
    SBL_RUN
  } sbl_state_e;

endpackage

// File: hdl/sbl_lock_gate.sv
// Purpose: Combines primary and secondary locks and grants operations.
// Assumes: Request signals come from the same clock domain.
// Notes:   Purely combinational; no state.
`timescale 1ns/1ps
module sbl_lock_gate (
  // Primary lock inputs
  input wire logic prim_tst_lock,
  input wire logic [3:0] prim_low_lock,
  // Secondary lock inputs
  input wire logic sec_tst_lock,
  input wire logic [3:0] sec_low_lock,
  // Operation request
  input wire logic pe_req,
  input wire logic pe_erase,
  input wire logic pe_tst,
  input wire logic [1:0] pe_sector,
  // Results
  output logic eff_tst_lock,
  output logic [3:0] eff_low_lock,
  output logic pe_grant
);

  // Either register locking a sector locks it
  assign eff_tst_lock = prim_tst_lock | sec_tst_lock;
  assign eff_low_lock = prim_low_lock | sec_low_lock;

  // Test sector erase is refused whatever the locks say
  always_comb begin
    if (!pe_req) begin
      pe_grant = 1'b0;
    end else if (pe_tst) begin
      pe_grant = !eff_tst_lock && !pe_erase;
    end else begin
      pe_grant = !eff_low_lock[pe_sector];
    end
  end

endmodule

// File: hdl/sbl_top.sv
// Purpose: Secondary block lock register for the data flash, APB slave.
// Assumes: Interlock, done and suspend come from the flash controller
//          on clk; the nonvolatile word arrives with nv_valid.
// Notes:   Bus stalls (pready low) until the nonvolatile word is loaded.
`timescale 1ns/1ps
module sbl_top #(
  parameter logic [3:0] SEC_PRESENT = sbl_pkg::SEC_PRESENT_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sbl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Nonvolatile word load
  input wire logic [31:0] nv_word,
  input wire logic nv_valid,
  // Flash controller status
  input wire logic interlock_wr,
  input wire logic op_done,
  input wire logic hv_suspended,
  // Primary lock register bits
  input wire logic prim_tst_lock,
  input wire logic [3:0] prim_low_lock,
  // Program/erase request
  input wire logic pe_req,
  input wire logic pe_erase,
  input wire logic pe_tst,
  input wire logic [1:0] pe_sector,
  // Lock results
  output logic eff_tst_lock,
  output logic [3:0] eff_low_lock,
  output logic pe_grant,
  output logic lock_loaded
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sbl_pkg::sbl_state_e st;
    logic secondary_lock_enable;
    logic tst;
    logic [3:0] low;
    logic busy;
    logic [31:0] rdata;
  } sbl_regs_s;

  sbl_regs_s q_reg;
  sbl_regs_s q_next;

  logic hit;
  logic setup;
  logic wr_acc;
  logic pwd_match;
  logic wr_ok;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Address match ignores nothing; any other offset is an error
  assign hit = paddr == sbl_pkg::SECONDARY_BLOCK_LOCK_OFS;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pready && hit;
  assign pwd_match = pwdata == sbl_pkg::PWD;
  // Lock writes are ignored, not stalled, while an operation runs or is suspended
  assign wr_ok = q_reg.secondary_lock_enable
    && !q_reg.busy
    && !hv_suspended;

  // Handshake held off until the load is done
  assign pready = q_reg.st == sbl_pkg::SBL_RUN;
  assign pslverr = psel && penable && pready && !hit;
  assign prdata = q_reg.rdata;
  assign lock_loaded = q_reg.st == sbl_pkg::SBL_RUN;

  // Read view: unused upper low bits read as ones, others as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_word[sbl_pkg::SLE_BIT] = q_reg.secondary_lock_enable;
    rd_word[sbl_pkg::STS_BIT] = q_reg.tst;
    rd_word[sbl_pkg::LOW_W-1:sbl_pkg::SEC_N] =
      sbl_pkg::LOW_UNUSED_ONES;
    rd_word[sbl_pkg::SEC_N-1:0] = q_reg.low;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    q_next = q_reg;
    unique case (q_reg.st)
      sbl_pkg::SBL_LOAD: begin
        // Copy the lock bits of the nonvolatile word (its bit 31 is not loaded); absent sectors stay locked
        if (nv_valid) begin
          q_next.tst = nv_word[sbl_pkg::STS_BIT];
          q_next.low = nv_word[sbl_pkg::SEC_N-1:0]
            | ~SEC_PRESENT;
          q_next.st = sbl_pkg::SBL_RUN;
          // A read stalled behind the load gets no setup edge in the
          // run state, so its data is built here from the new bits
          q_next.rdata = 32'h0000_0000;
          if (hit) begin
            q_next.rdata[sbl_pkg::STS_BIT] = q_next.tst;
            q_next.rdata[sbl_pkg::LOW_W-1:sbl_pkg::SEC_N] =
              sbl_pkg::LOW_UNUSED_ONES;
            q_next.rdata[sbl_pkg::SEC_N-1:0] = q_next.low;
          end
        end
      end
      sbl_pkg::SBL_RUN: begin
        // Register read data sampled in the setup phase
        if (setup) begin
          q_next.rdata = hit ? rd_word : 32'h0000_0000;
        end
        if (wr_acc) begin
          if (pwd_match) begin
            q_next.secondary_lock_enable = 1'b1;
          end else if (wr_ok) begin
            // Enable bit is not written from the data word
            q_next.tst = pwdata[sbl_pkg::STS_BIT];
            q_next.low = pwdata[sbl_pkg::SEC_N-1:0]
              | ~SEC_PRESENT;
          end
        end
      end
    endcase
    // Interlock wins over a completion in the same cycle
    if (interlock_wr) begin
      q_next.busy = 1'b1;
    end else if (op_done) begin
      q_next.busy = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset value is the erased word: everything locked
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_reg.st <= sbl_pkg::SBL_LOAD;
      q_reg.secondary_lock_enable <= 1'b0;
      q_reg.tst <= sbl_pkg::RST_LOCK;
      q_reg.low <= {sbl_pkg::SEC_N{sbl_pkg::RST_LOCK}};
      q_reg.busy <= 1'b0;
      q_reg.rdata <= 32'h0000_0000;
    end else begin
      q_reg <= q_next;
    end
  end

  // ----------------------------------------------------------------
  // Lock combination
  // ----------------------------------------------------------------
  sbl_lock_gate u_gate (
    .prim_tst_lock(prim_tst_lock),
    .prim_low_lock(prim_low_lock),
    .sec_tst_lock(q_reg.tst),
    .sec_low_lock(q_reg.low),
    .pe_req(pe_req),
    .pe_erase(pe_erase),
    .pe_tst(pe_tst),
    .pe_sector(pe_sector),
    .eff_tst_lock(eff_tst_lock),
    .eff_low_lock(eff_low_lock),
    .pe_grant(pe_grant)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_wr_pwd;
    wr_acc && pwd_match;
  endsequence

  sequence s_wr_plain;
    wr_acc && !pwd_match;
  endsequence

  sequence s_rd_acc;
    psel && penable && !pwrite && pready && hit;
  endsequence

  AST_SLE_STICKY: assert property (
    q_reg.secondary_lock_enable |=> q_reg.secondary_lock_enable)
    else $error("enable bit cleared before reset");

  AST_SLE_PWD_ONLY: assert property (
    $rose(q_reg.secondary_lock_enable) |-> $past(wr_acc && pwd_match))
    else $error("enable bit set without password");

  AST_SLE_PWD_SETS: assert property (
    s_wr_pwd |=> q_reg.secondary_lock_enable)
    else $error("password write did not set enable");

  AST_NO_WR_DISABLED: assert property (
    s_wr_plain ##0 !q_reg.secondary_lock_enable |=> $stable(q_reg.tst)
      && $stable(q_reg.low))
    else $error("lock changed while disabled");

  AST_WR_ENABLED: assert property (
    s_wr_plain ##0 wr_ok |=>
      q_reg.low == (($past(pwdata[3:0])) | ~SEC_PRESENT)
      && q_reg.tst == $past(pwdata[sbl_pkg::STS_BIT]))
    else $error("allowed lock write not stored");

  AST_BUSY_BLOCK: assert property (
    interlock_wr ##1 (!op_done ##0 s_wr_plain) |=>
      $stable(q_reg.low) && $stable(q_reg.tst))
    else $error("lock written during operation");

  AST_SUSP_BLOCK: assert property (
    s_wr_plain ##0 hv_suspended |=> $stable(q_reg.low))
    else $error("lock written while suspended");

  AST_EFF_OR: assert property (
    eff_low_lock == (prim_low_lock | q_reg.low)
      && eff_tst_lock == (prim_tst_lock | q_reg.tst))
    else $error("effective lock not OR of both");

  AST_TST_ERASE: assert property (
    pe_req && pe_tst && pe_erase |-> !pe_grant)
    else $error("test block erase granted");

  AST_SECTOR_LOCK: assert property (
    pe_req && !pe_tst && q_reg.low[pe_sector] |-> !pe_grant)
    else $error("locked sector granted");

  AST_UPPER_ONES: assert property (
    s_rd_acc |-> prdata[15:4] == sbl_pkg::LOW_UNUSED_ONES
      && prdata[30:21] == 10'h000)
    else $error("read-only bits wrong");

  AST_ABSENT_LOCKED: assert property (
    (q_reg.low & ~SEC_PRESENT) == ~SEC_PRESENT || !pready)
    else $error("absent sector unlocked");

  AST_LOAD: assert property (
    reset_n && !pready && nv_valid |=> pready
      && q_reg.low == ($past(nv_word[3:0]) | ~SEC_PRESENT))
    else $error("nonvolatile word not loaded");

  AST_READ_DATA: assert property (
    psel && !penable && !hit ##1 psel && penable |-> prdata == 32'h0)
    else $error("unmapped read not zero");

  // ----------------------------------------------------------------
  // Further checks: reset view, busy flag, grant and read view
  // ----------------------------------------------------------------
  sequence s_access_now;
    psel && penable && pready;
  endsequence

  AST_RESET_CLEAN: assert property (
    $rose(reset_n) |-> !q_reg.secondary_lock_enable && !pready)
    else $error("enable or ready set after reset");

  AST_PWD_KEEPS_LOCKS: assert property (
    s_wr_pwd |=> $stable(q_reg.tst) && $stable(q_reg.low))
    else $error("password write changed a lock");

  AST_BUSY_SET: assert property (
    interlock_wr |=> q_reg.busy)
    else $error("interlock did not mark busy");

  AST_BUSY_HOLD: assert property (
    q_reg.busy && !op_done |=> q_reg.busy)
    else $error("busy dropped without completion");

  AST_BUSY_CLEAR: assert property (
    op_done && !interlock_wr |=> !q_reg.busy)
    else $error("completion did not clear busy");

  AST_SUSP_TST: assert property (
    s_wr_plain ##0 hv_suspended |=> $stable(q_reg.tst))
    else $error("test lock written while suspended");

  AST_NO_LOAD_ENABLE: assert property (
    !lock_loaded |=> !q_reg.secondary_lock_enable)
    else $error("enable set before load");

  AST_TST_BLOCK: assert property (
    pe_req && pe_tst && eff_tst_lock |-> !pe_grant)
    else $error("locked test sector granted");

  AST_TST_FREE: assert property (
    pe_req && pe_tst && !pe_erase && !prim_tst_lock && !q_reg.tst
      |-> pe_grant)
    else $error("free test sector refused");

  AST_SECTOR_FREE: assert property (
    pe_req && !pe_tst && !prim_low_lock[pe_sector]
      && !q_reg.low[pe_sector] |-> pe_grant)
    else $error("free sector refused");

  AST_NO_REQ: assert property (
    !pe_req |-> !pe_grant)
    else $error("grant without request");

  AST_HIT_NO_ERR: assert property (
    s_access_now ##0 hit |-> !pslverr)
    else $error("error on the mapped register");

  AST_UNMAPPED_ERR: assert property (
    s_access_now ##0 !hit |-> pslverr)
    else $error("no error on an unmapped offset");

  AST_READ_VIEW: assert property (
    setup && hit ##1 s_access_now |->
      prdata[sbl_pkg::SLE_BIT] == q_reg.secondary_lock_enable
      && prdata[sbl_pkg::STS_BIT] == q_reg.tst
      && prdata[sbl_pkg::SEC_N-1:0] == q_reg.low)
    else $error("read data does not show the register");

endmodule

// File: bench/sbl_top_tb.sv
// Purpose: Self-checking bench for the secondary block lock register.
// Assumes: APB master tasks; a second instance has sector 2 absent.
// Notes:   Waits on pready are bounded; a watchdog cuts a hang short.
`timescale 1ns/1ps
module data_flash_secondary_block_lock_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, reset_n, psel, penable, pwrite, nv_valid, interlock_wr;
  logic op_done, hv_suspended, prim_tst_lock, pe_req, pe_erase, pe_tst;
  logic [11:0] paddr;
  logic [31:0] pwdata, nv_word, prdata, prdata2, q, q2;
  logic [3:0] prim_low_lock, eff_low_lock;
  logic [1:0] pe_sector;
  logic pready, pslverr, eff_tst_lock, pe_grant, lock_loaded, qe;
  int err_total = 0;
  int num_checks = 0;
  localparam logic [11:0] REG = sbl_pkg::SECONDARY_BLOCK_LOCK_OFS;

  // Both instances share one bus; only read data is kept apart
  sbl_top uut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nv_word(nv_word), .nv_valid(nv_valid), .interlock_wr(interlock_wr),
    .op_done(op_done), .hv_suspended(hv_suspended),
    .prim_tst_lock(prim_tst_lock), .prim_low_lock(prim_low_lock),
    .pe_req(pe_req), .pe_erase(pe_erase), .pe_tst(pe_tst),
    .pe_sector(pe_sector), .eff_tst_lock(eff_tst_lock),
    .eff_low_lock(eff_low_lock), .pe_grant(pe_grant),
    .lock_loaded(lock_loaded));
  sbl_top #(.SEC_PRESENT(4'hB)) uut_abs (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata2), .pready(), .pslverr(),
    .nv_word(nv_word), .nv_valid(nv_valid), .interlock_wr(interlock_wr),
    .op_done(op_done), .hv_suspended(hv_suspended),
    .prim_tst_lock(prim_tst_lock), .prim_low_lock(prim_low_lock),
    .pe_req(pe_req), .pe_erase(pe_erase), .pe_tst(pe_tst),
    .pe_sector(pe_sector), .eff_tst_lock(), .eff_low_lock(),
    .pe_grant(), .lock_loaded());

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; entered just after a rising edge
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Hold the request until a rising edge samples pready high
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) chk("pready", 32'h1, 32'h0);
    q = prdata;
    q2 = prdata2;
    qe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(logic [31:0] e1, logic [31:0] e2);
    apb(1'b0, REG, 32'h0);
    chk("reg", e1, q);
    chk("reg_abs", e2, q2);
  endtask

  // Present an operation query and judge the grant one cycle later
  task automatic gq(logic e, logic t, logic [1:0] s, logic pt,
                    logic [3:0] pl, logic exp);
    pe_req <= 1'b1;
    pe_erase <= e;
    pe_tst <= t;
    pe_sector <= s;
    prim_tst_lock <= pt;
    prim_low_lock <= pl;
    @(posedge clk);
    chk("pe_grant", {31'h0, exp}, {31'h0, pe_grant});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_load();
    repeat (3) @(posedge clk);
    chk("lock_loaded", 32'h0, {31'h0, lock_loaded});
    nv_valid <= 1'b1;
    rd(32'h0010FFF2, 32'h0010FFF6);
    chk("lock_loaded", 32'h1, {31'h0, lock_loaded});
    apb(1'b0, 12'h010, 32'h0);
    chk("pslverr", 32'h1, {31'h0, qe});
    $display("load test done");
  endtask

  task automatic t_enable();
    apb(1'b1, REG, 32'h0);
    rd(32'h0010FFF2, 32'h0010FFF6);
    apb(1'b1, REG, 32'h80000000);
    rd(32'h0010FFF2, 32'h0010FFF6);
    apb(1'b1, REG, sbl_pkg::PWD);
    rd(32'h8010FFF2, 32'h8010FFF6);
    apb(1'b1, REG, 32'h0);
    rd(32'h8000FFF0, 32'h8000FFF4);
    apb(1'b1, REG, 32'hFFFFFFFF);
    rd(32'h8010FFFF, 32'h8010FFFF);
    $display("enable test done");
  endtask

  task automatic t_busy();
    interlock_wr <= 1'b1;
    @(posedge clk);
    interlock_wr <= 1'b0;
    apb(1'b1, REG, 32'h0);
    rd(32'h8010FFFF, 32'h8010FFFF);
    op_done <= 1'b1;
    @(posedge clk);
    op_done <= 1'b0;
    apb(1'b1, REG, 32'h1);
    rd(32'h8000FFF1, 32'h8000FFF5);
    hv_suspended <= 1'b1;
    apb(1'b1, REG, 32'h0);
    rd(32'h8000FFF1, 32'h8000FFF5);
    hv_suspended <= 1'b0;
    apb(1'b1, REG, 32'h0);
    rd(32'h8000FFF0, 32'h8000FFF4);
    $display("busy test done");
  endtask

  task automatic t_gate();
    for (int s = 0; s < 4; s++) begin
      gq(1'b0, 1'b0, 2'(s), 1'b0, 4'h1 << s, 1'b0);
      chk("eff_low", 32'h1 << s, {28'h0, eff_low_lock});
      gq(1'b1, 1'b0, 2'(s), 1'b0, 4'h0, 1'b1);
    end
    gq(1'b0, 1'b0, 2'd2, 1'b0, 4'h0, 1'b1);
    apb(1'b1, REG, 32'h4);
    gq(1'b0, 1'b0, 2'd2, 1'b0, 4'h0, 1'b0);
    gq(1'b0, 1'b1, 2'd0, 1'b0, 4'h0, 1'b1);
    gq(1'b1, 1'b1, 2'd0, 1'b0, 4'h0, 1'b0);
    gq(1'b0, 1'b1, 2'd0, 1'b1, 4'h0, 1'b0);
    chk("eff_tst", 32'h1, {31'h0, eff_tst_lock});
    apb(1'b1, REG, 32'h00100000);
    gq(1'b0, 1'b1, 2'd0, 1'b0, 4'h0, 1'b0);
    $display("gate test done");
  endtask

  task automatic t_reset();
    nv_word <= 32'hFFFFFFFF;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(32'h0010FFFF, 32'h0010FFFF);
    $display("reset test done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, nv_valid, interlock_wr, op_done} = 6'h00;
    {hv_suspended, prim_tst_lock, pe_req, pe_erase, pe_tst} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    nv_word = 32'h00100002;
    prim_low_lock = 4'h0;
    pe_sector = 2'h0;
    reset_n = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_load();
    t_enable();
    t_busy();
    t_gate();
    t_reset();
    conclude();
  end

  // The run needs under a thousand cycles; allow a wide margin
  initial begin
    #50000;
    err_total++;
    $display("[ERR] watchdog expected finish seen timeout");
    conclude();
  end
endmodule
